// [src/pcep_pkg.sv]
package pcep_pkg;

  // Clocking: the block runs on pclk; the original device clock figure is kept for reference.
  localparam int PCLK_PERIOD_PS  = 4000;
  localparam int DEV_CLK_KHZ     = 5000;
  localparam int DEV_CLK_TOL_PCT = 10;

  // Least strobe width and its cycle count, rounded up.
  localparam int STB_MIN_NS  = 1000;
  localparam int STB_MIN_CYC = (STB_MIN_NS * 1000 + PCLK_PERIOD_PS - 1) / PCLK_PERIOD_PS;
  localparam int CNT_W       = 9;

  // Function indices of the four strobe lines.
  localparam int NFUNC    = 4;
  localparam int FN_FEED  = 0;
  localparam int FN_WHEEL = 1;
  localparam int FN_CAR   = 2;
  localparam int FN_OPT   = 3;

  // Command word layout.
  localparam int WORD_W = 12;
  localparam int HI_W   = 4;
  localparam int LO_W   = 8;

  // Register byte offsets.
  localparam int          ADDR_W       = 8;
  localparam logic [7:0]  REG_STATUS   = 8'h00;
  localparam logic [7:0]  REG_CONTROL  = 8'h04;
  localparam logic [7:0]  REG_CLEAR    = 8'h08;
  localparam logic [7:0]  REG_FILE_HI  = 8'h0C;
  localparam logic [7:0]  REG_FILE_LO  = 8'h10;

  // Status register fields.
  localparam int ST_LATCH  = 0;
  localparam int ST_PBH    = 4;
  localparam int ST_PBV    = 5;
  localparam int ST_RIBBON = 6;
  localparam int ST_REINIT = 7;
  localparam int ST_CTLRST = 8;
  localparam int ST_CHECK  = 9;
  localparam int ST_CARDEC = 10;
  localparam int ST_WHEELF = 11;
  localparam int ST_FIDX   = 13;

  // Control register fields.
  localparam int CT_CHECK = 0;
  localparam int CT_PAUSE = 1;
  localparam int CT_READY = 2;
  localparam int CT_PAPER = 3;

  // Clear decoder command bits.
  localparam int CL_REINIT_CLR = 0;
  localparam int CL_REINIT_SET = 1;
  localparam int CL_LATCH_CLR  = 2;
  localparam int CL_RIBBON_CLR = 3;
  localparam int CL_CARDEC_CLR = 4;
  localparam int CL_WHEELF_SET = 5;
  localparam int CL_POWERUP    = 6;

  // Reset values.
  localparam logic [1:0]  WHEELF_PRESET = 2'h3;
  localparam logic [31:0] RD_ZERO       = 32'h0000_0000;

  typedef logic [WORD_W-1:0] pcep_word_t;
  typedef logic [1:0]        pcep_fidx_t;

  typedef enum logic [1:0] {
    STG_IDLE  = 2'b00,
    STG_SYNC  = 2'b01,
    STG_ARMED = 2'b10
  } pcep_stage_t;

  typedef struct packed {
    pcep_stage_t                  stage;
    logic [CNT_W-1:0]             cnt;
    pcep_fidx_t                   fidx;
    logic [NFUNC-1:0]             latch;
    logic                         pbh;
    logic                         pbv;
    logic                         ribbon;
    logic                         reinit;
    logic                         ctl_rst;
    logic                         check;
    logic                         pause;
    logic                         prn_ready;
    logic                         paper_out;
    logic                         car_dec;
    logic [1:0]                   wheel_f;
    logic [NFUNC-1:0][WORD_W-1:0] file;
    logic [NFUNC-1:0]             stb_prev;
    logic                         rst_prev;
    logic                         wr_n;
    logic [NFUNC-1:0]             rdy_n;
    logic                         stat_ready_n;
    logic                         stat_paper;
    logic                         fault_n;
    logic                         pready;
    logic                         pslverr;
    logic [31:0]                  prdata;
  } pcep_state_t;

endpackage

// [src/pcep_port.sv]
`timescale 1ns/1ps
`default_nettype none

module pcep_port #(
  parameter int STB_MIN_CYCLES = pcep_pkg::STB_MIN_CYC
) (
  // Clock and reset
  input  wire logic                           pclk,
  input  wire logic                           presetn,
  // APB slave
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [pcep_pkg::ADDR_W-1:0]    paddr,
  input  wire logic [31:0]                    pwdata,
  output logic                                pready,
  output logic                                pslverr,
  output logic [31:0]                         prdata,
  // Controller interface inputs
  input  wire logic                           unit_select_line_n,
  input  wire logic [pcep_pkg::WORD_W-1:0]    data_n,
  input  wire logic [pcep_pkg::NFUNC-1:0]     strobe_n,
  input  wire logic                           restore_n,
  input  wire logic                           ribbon_lift_n,
  input  wire logic                           ribbon_depleted_n,
  // Controller interface outputs
  output logic                                printer_ready_n,
  output logic                                paper_exhausted,
  output logic                                fault_n,
  output logic                                feed_ready_out,
  output logic                                wheel_ready_out,
  output logic                                carriage_ready_out,
  output logic                                option_ready_out,
  // Command file write strobe, visible for observation
  output logic                                file_write_n
);

  ////////////////////////////////////////////////////////////////////////////

  // Maps the two file address bits onto a function index.
  function automatic pcep_pkg::pcep_fidx_t addr_to_fidx(input logic hi, input logic lo);
    pcep_pkg::pcep_fidx_t f;
    unique case ({hi, lo})
      2'b00: f = pcep_pkg::pcep_fidx_t'(pcep_pkg::FN_FEED);
      2'b11: f = pcep_pkg::pcep_fidx_t'(pcep_pkg::FN_WHEEL);
      2'b10: f = pcep_pkg::pcep_fidx_t'(pcep_pkg::FN_CAR);
      2'b01: f = pcep_pkg::pcep_fidx_t'(pcep_pkg::FN_OPT);
    endcase
    return f;
  endfunction

  // Register address match, used by the read and the write path.
  function automatic logic hit(input logic [pcep_pkg::ADDR_W-1:0] a,
                               input logic [7:0] off);
    return a == off;
  endfunction

  ////////////////////////////////////////////////////////////////////////////

  pcep_pkg::pcep_state_t s_q;
  pcep_pkg::pcep_state_t s_d;

  logic                        selected;
  logic                        ok;
  logic [pcep_pkg::NFUNC-1:0]  stb;
  logic                        any_stb;
  logic                        file_addr_bit_hi;
  logic                        file_addr_bit_lo;
  pcep_pkg::pcep_word_t        cmd_word;
  logic                        wr_acc;
  logic                        rd_setup;
  logic [31:0]                 status_word;
  logic [31:0]                 rd_val;
  logic                        rd_err;
  logic [31:0]                 clr;
  logic [pcep_pkg::NFUNC-1:0]  set_latch;
  logic                        ribbon_set;
  logic                        reinit_set;
  logic                        ctl_rst_set;
  logic [pcep_pkg::CNT_W-1:0]  stb_last;

  assign stb_last = pcep_pkg::CNT_W'(STB_MIN_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    // Select gating of the controller inputs.
    selected = ~unit_select_line_n;
    ok       = selected & ~s_q.check & ~s_q.reinit & ~s_q.pause;
    stb      = selected ? ~strobe_n : '0;
    any_stb  = ok & (|stb) & (s_q.latch == '0);
    // Address bits are wheel-or-carriage and wheel-or-option.
    file_addr_bit_hi = stb[pcep_pkg::FN_WHEEL] | stb[pcep_pkg::FN_CAR];
    file_addr_bit_lo = stb[pcep_pkg::FN_WHEEL] | stb[pcep_pkg::FN_OPT];
    cmd_word = ~data_n;

    wr_acc   = psel & penable & s_q.pready & pwrite;
    rd_setup = psel & ~penable & ~pwrite;
    clr      = (wr_acc && hit(paddr, pcep_pkg::REG_CLEAR)) ? pwdata : '0;

    status_word = pcep_pkg::RD_ZERO;
    status_word[pcep_pkg::ST_LATCH +: pcep_pkg::NFUNC] = s_q.latch;
    status_word[pcep_pkg::ST_PBH]    = s_q.pbh;
    status_word[pcep_pkg::ST_PBV]    = s_q.pbv;
    status_word[pcep_pkg::ST_RIBBON] = s_q.ribbon;
    status_word[pcep_pkg::ST_REINIT] = s_q.reinit;
    status_word[pcep_pkg::ST_CTLRST] = s_q.ctl_rst;
    status_word[pcep_pkg::ST_CHECK]  = s_q.check;
    status_word[pcep_pkg::ST_CARDEC] = s_q.car_dec;
    status_word[pcep_pkg::ST_WHEELF +: 2] = s_q.wheel_f;
    status_word[pcep_pkg::ST_FIDX +: 2]   = s_q.fidx;

    rd_val = pcep_pkg::RD_ZERO;
    rd_err = 1'b0;
    if (hit(paddr, pcep_pkg::REG_STATUS)) begin
      rd_val = status_word;
    end else if (hit(paddr, pcep_pkg::REG_CONTROL)) begin
      rd_val[pcep_pkg::CT_CHECK] = s_q.check;
      rd_val[pcep_pkg::CT_PAUSE] = s_q.pause;
      rd_val[pcep_pkg::CT_READY] = s_q.prn_ready;
      rd_val[pcep_pkg::CT_PAPER] = s_q.paper_out;
    end else if (hit(paddr, pcep_pkg::REG_CLEAR)) begin
      rd_val = pcep_pkg::RD_ZERO;
    end else if (hit(paddr, pcep_pkg::REG_FILE_HI)) begin
      // The high register returns the top bits of the word for the last written function.
      rd_val[pcep_pkg::HI_W-1:0] =
        s_q.file[s_q.fidx][pcep_pkg::WORD_W-1 -: pcep_pkg::HI_W];
    end else if (hit(paddr, pcep_pkg::REG_FILE_LO)) begin
      rd_val[pcep_pkg::LO_W-1:0] = s_q.file[s_q.fidx][pcep_pkg::LO_W-1:0];
    end else begin
      rd_err = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    s_d         = s_q;
    set_latch   = '0;
    ribbon_set  = 1'b0;
    reinit_set  = 1'b0;
    ctl_rst_set = 1'b0;
    s_d.wr_n    = 1'b1;

    // Strobe acceptance: synchronise, arm and write, then qualify the width.
    unique case (s_q.stage)
      pcep_pkg::STG_IDLE: begin
        if (any_stb) begin
          s_d.stage = pcep_pkg::STG_SYNC;
        end
      end
      pcep_pkg::STG_SYNC: begin
        if (any_stb) begin
          s_d.stage = pcep_pkg::STG_ARMED;
          s_d.cnt   = '0;
          s_d.fidx  = addr_to_fidx(file_addr_bit_hi, file_addr_bit_lo);
          s_d.wr_n  = 1'b0;
          s_d.file[addr_to_fidx(file_addr_bit_hi, file_addr_bit_lo)] = cmd_word;
        end else begin
          s_d.stage = pcep_pkg::STG_IDLE;
        end
      end
      pcep_pkg::STG_ARMED: begin
        // A strobe that lets go early, or a lost qualifier, never latches.
        if (!ok || stb == '0) begin
          s_d.stage = pcep_pkg::STG_IDLE;
        end else if (s_q.cnt >= stb_last) begin
          s_d.stage = pcep_pkg::STG_IDLE;
          // Every strobe still low latches, so a combined command keeps all its functions.
          set_latch = stb;
        end else begin
          s_d.cnt = s_q.cnt + pcep_pkg::CNT_W'(1);
        end
      end
      default: begin
        s_d.stage = pcep_pkg::STG_IDLE;
      end
    endcase

    // Print-before flags sample the wheel latch as another latch sets.
    if (set_latch[pcep_pkg::FN_CAR]) begin
      s_d.pbh = s_q.latch[pcep_pkg::FN_WHEEL] | set_latch[pcep_pkg::FN_WHEEL];
    end
    if (set_latch[pcep_pkg::FN_FEED] || set_latch[pcep_pkg::FN_OPT]) begin
      s_d.pbv = s_q.latch[pcep_pkg::FN_WHEEL] | set_latch[pcep_pkg::FN_WHEEL];
    end

    // Ribbon lift is taken only on the falling edge of the wheel strobe.
    s_d.stb_prev = strobe_n;
    if (selected && s_q.stb_prev[pcep_pkg::FN_WHEEL]
        && !strobe_n[pcep_pkg::FN_WHEEL] && !ribbon_lift_n) begin
      ribbon_set = 1'b1;
    end

    // Controller restore acts on its falling edge while selected.
    s_d.rst_prev = restore_n;
    if (selected && s_q.rst_prev && !restore_n) begin
      reinit_set  = 1'b1;
      ctl_rst_set = 1'b1;
    end
    if (clr[pcep_pkg::CL_REINIT_SET] || clr[pcep_pkg::CL_POWERUP]) begin
      reinit_set = 1'b1;
    end

    // Clear decoder; a hardware set in the same cycle wins over the clear.
    if (clr[pcep_pkg::CL_LATCH_CLR] || clr[pcep_pkg::CL_POWERUP]) begin
      s_d.latch = '0;
    end
    s_d.latch = s_d.latch | set_latch;
    if (clr[pcep_pkg::CL_RIBBON_CLR] || clr[pcep_pkg::CL_POWERUP]) begin
      s_d.ribbon = 1'b0;
    end
    s_d.ribbon = s_d.ribbon | ribbon_set;
    if (clr[pcep_pkg::CL_CARDEC_CLR] || clr[pcep_pkg::CL_POWERUP]) begin
      s_d.car_dec = 1'b0;
    end
    if (clr[pcep_pkg::CL_WHEELF_SET] || clr[pcep_pkg::CL_POWERUP]) begin
      s_d.wheel_f = pcep_pkg::WHEELF_PRESET;
    end
    if (clr[pcep_pkg::CL_REINIT_CLR]) begin
      s_d.reinit  = 1'b0;
      s_d.ctl_rst = 1'b0;
    end
    s_d.reinit  = s_d.reinit | reinit_set;
    s_d.ctl_rst = s_d.ctl_rst | ctl_rst_set;

    // Control register; check may only be dropped while reinit is set.
    if (wr_acc && hit(paddr, pcep_pkg::REG_CONTROL)) begin
      s_d.pause     = pwdata[pcep_pkg::CT_PAUSE];
      s_d.prn_ready = pwdata[pcep_pkg::CT_READY];
      s_d.paper_out = pwdata[pcep_pkg::CT_PAPER];
      if (pwdata[pcep_pkg::CT_CHECK] || s_q.reinit) begin
        s_d.check = pwdata[pcep_pkg::CT_CHECK];
      end
    end

    // Interface status outputs, registered for clean pins.
    for (int i = 0; i < pcep_pkg::NFUNC; i++) begin
      s_d.rdy_n[i] = ~(ok & (s_q.latch == '0));
    end
    if (!ribbon_depleted_n) begin
      s_d.rdy_n[pcep_pkg::FN_WHEEL] = 1'b1;
    end
    s_d.stat_ready_n = ~(selected & s_q.prn_ready);
    s_d.stat_paper   = selected & s_q.paper_out;
    s_d.fault_n      = ~(s_q.check | s_q.reinit);

    // APB: data is captured in setup and presented with pready in the access cycle.
    if (psel && !penable) begin
      s_d.pready  = 1'b1;
      s_d.pslverr = rd_err;
      s_d.prdata  = rd_setup ? rd_val : pcep_pkg::RD_ZERO;
    end else begin
      s_d.pready  = 1'b0;
      s_d.pslverr = 1'b0;
      s_d.prdata  = pcep_pkg::RD_ZERO;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  // Every register runs on pclk; the slow device clock is not reproduced.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q              <= '0;
      s_q.stage        <= pcep_pkg::STG_IDLE;
      s_q.wheel_f      <= pcep_pkg::WHEELF_PRESET;
      s_q.stb_prev     <= '1;
      s_q.rst_prev     <= 1'b1;
      s_q.wr_n         <= 1'b1;
      s_q.rdy_n        <= '1;
      s_q.stat_ready_n <= 1'b1;
      s_q.fault_n      <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  assign pready             = s_q.pready;
  assign pslverr            = s_q.pslverr;
  assign prdata             = s_q.prdata;
  assign printer_ready_n    = s_q.stat_ready_n;
  assign paper_exhausted    = s_q.stat_paper;
  assign fault_n            = s_q.fault_n;
  assign feed_ready_out     = s_q.rdy_n[pcep_pkg::FN_FEED];
  assign wheel_ready_out    = s_q.rdy_n[pcep_pkg::FN_WHEEL];
  assign carriage_ready_out = s_q.rdy_n[pcep_pkg::FN_CAR];
  assign option_ready_out   = s_q.rdy_n[pcep_pkg::FN_OPT];
  assign file_write_n       = s_q.wr_n;

endmodule

`default_nettype wire

// [bench/pcep_ctrl_model.sv]
`timescale 1ns/1ps
`default_nettype none
module pcep_ctrl_model #(
  parameter int LEAD = 50,
  parameter int HOLD = 250
) (
  // Clock
  input  wire logic                        pclk,
  // Lines toward the block
  output logic [pcep_pkg::WORD_W-1:0]      data_n,
  output logic [3:0]                       strobe_n,
  output logic                             ribbon_lift_n
);
  initial begin
    data_n = 12'hFFF;
    strobe_n = 4'hF;
    ribbon_lift_n = 1'h1;
  end
  // A width below HOLD is only used where a too short strobe is wanted.
  task automatic send(input logic [3:0] stb, input logic [11:0] w, input logic rib,
                      input int width);
    @(posedge pclk);
    data_n <= ~w;
    ribbon_lift_n <= ~rib;
    repeat (LEAD) @(posedge pclk);
    strobe_n <= ~stb;
    repeat (width) @(posedge pclk);
    strobe_n <= 4'hF;
    repeat (LEAD) @(posedge pclk);
    // Released lines show the inverse, so a stale word can never pass as fresh.
    data_n <= w;
    ribbon_lift_n <= rib;
  endtask
endmodule
`default_nettype wire

// [bench/pcep_port_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module pcep_port_properties #(
  parameter int STB_MIN_CYCLES = 250
) (
  // Clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // Register bus
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  // Controller side
  input wire logic       unit_select_line_n,
  input wire logic [3:0] strobe_n,
  input wire logic       restore_n,
  input wire logic       fault_n,
  input wire logic       printer_ready_n,
  input wire logic       paper_exhausted,
  input wire logic       feed_ready_out,
  input wire logic       wheel_ready_out,
  input wire logic       carriage_ready_out,
  input wire logic       option_ready_out,
  input wire logic       file_write_n
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [3:0] rdy;
  assign rdy = {option_ready_out, carriage_ready_out, wheel_ready_out, feed_ready_out};
  ////////////////////////////////////////////////////////////////////////////////
  a_apb_answer: assert property (psel && !penable |=> pready)
    else $error("register access not answered in the next cycle");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error response outside the answer cycle");
  a_desel_quiet: assert property (unit_select_line_n |=> rdy == 4'hF && printer_ready_n && !paper_exhausted)
    else $error("status driven while deselected");
  a_desel_nowrite: assert property (unit_select_line_n [*3] |-> file_write_n)
    else $error("file written while deselected");
  a_write_cause: assert property ($fell(file_write_n) |-> $past(strobe_n) != 4'hF && !$past(unit_select_line_n))
    else $error("file write without a selected strobe");
  a_write_pulse: assert property (!file_write_n |=> file_write_n)
    else $error("file write pulse longer than one cycle");
  // The eight-cycle window only covers short qualification counts.
  a_busy_after: assert property ((STB_MIN_CYCLES <= 5) && $fell(file_write_n) ##0
    ((strobe_n != 4'hF) && $stable(strobe_n)) [*8] |-> rdy == 4'hF)
    else $error("held strobe did not raise busy");
  a_fault_busy: assert property (!fault_n |-> rdy == 4'hF)
    else $error("ready shown during fault");
  a_restore_fault: assert property ($fell(restore_n) && !unit_select_line_n |-> ##[1:3] !fault_n)
    else $error("restore request did not show fault");
endmodule
bind pcep_port pcep_port_properties #(.STB_MIN_CYCLES(STB_MIN_CYCLES)) u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .unit_select_line_n(unit_select_line_n), .strobe_n(strobe_n),
  .restore_n(restore_n), .fault_n(fault_n), .printer_ready_n(printer_ready_n),
  .paper_exhausted(paper_exhausted), .feed_ready_out(feed_ready_out),
  .wheel_ready_out(wheel_ready_out), .carriage_ready_out(carriage_ready_out),
  .option_ready_out(option_ready_out), .file_write_n(file_write_n));
`default_nettype wire

// [bench/test_printer_command_entry_port.sv]
`timescale 1ns/1ps
`default_nettype none
module test_printer_command_entry_port;
  localparam logic [7:0] ST = pcep_pkg::REG_STATUS;
  localparam logic [7:0] CT = pcep_pkg::REG_CONTROL;
  localparam logic [7:0] CL = pcep_pkg::REG_CLEAR;
  localparam logic [7:0] FH = pcep_pkg::REG_FILE_HI;
  localparam logic [7:0] FL = pcep_pkg::REG_FILE_LO;
  logic        pclk, presetn, psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [11:0] data_n;
  logic [3:0]  strobe_n;
  logic        unit_select_line_n, restore_n, ribbon_lift_n, ribbon_depleted_n;
  logic        pready, pslverr, fault_n, printer_ready_n, paper_exhausted, file_write_n;
  logic        feed_ready_out, wheel_ready_out, carriage_ready_out, option_ready_out;
  logic [6:0]  pv;
  int          err_count = 0;
  int          comparisons = 0;
  int          wcnt = 0;
  logic [11:0] words [4] = '{12'hA5C, 12'h3C1, 12'hF0F, 12'h81E};
  assign pv = {fault_n, printer_ready_n, paper_exhausted, option_ready_out,
               carriage_ready_out, wheel_ready_out, feed_ready_out};
  always @(negedge file_write_n) wcnt++;
  pcep_port #(.STB_MIN_CYCLES(4)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .unit_select_line_n(unit_select_line_n), .data_n(data_n), .strobe_n(strobe_n),
    .restore_n(restore_n), .ribbon_lift_n(ribbon_lift_n),
    .ribbon_depleted_n(ribbon_depleted_n), .printer_ready_n(printer_ready_n),
    .paper_exhausted(paper_exhausted), .fault_n(fault_n), .feed_ready_out(feed_ready_out),
    .wheel_ready_out(wheel_ready_out), .carriage_ready_out(carriage_ready_out),
    .option_ready_out(option_ready_out), .file_write_n(file_write_n));
  pcep_ctrl_model ctrl (.pclk(pclk), .data_n(data_n), .strobe_n(strobe_n),
    .ribbon_lift_n(ribbon_lift_n));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk_reg(input logic [31:0] g, input logic [31:0] x);
    comparisons++;
    if (g !== x) begin
      err_count++;
      $display("CHECK FAILED %0t: value %h, expected %h", $time, g, x);
    end
  endtask
  // Pins are levels, so three settled samples later is always past the lag.
  task automatic pins(input logic [6:0] x);
    repeat (3) @(negedge pclk);
    comparisons++;
    if (pv !== x) begin
      err_count++;
      $display("CHECK FAILED %0t: pins %b, expected %b", $time, pv, x);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    // Answer is taken at the very edge that samples pready high, then released.
    do @(posedge pclk); while (pready !== 1'h1);
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'h1, a, d, r, e);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'h0, a, 32'h0, r, e);
    chk_reg(r, x);
    chk_reg({31'h0, e}, {31'h0, xe});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_idle;
    rdc(ST, 32'h0000_1800, 1'h0);
    pins(7'h6F);
    @(posedge pclk);
    unit_select_line_n <= 1'h0;
    pins(7'h60);
    wr(CT, 32'h0000_000C);
    pins(7'h50);
    rdc(CT, 32'h0000_000C, 1'h0);
    rdc(8'h14, 32'h0, 1'h1);
    @(posedge pclk);
    unit_select_line_n <= 1'h1;
    pins(7'h6F);
    wr(CT, 32'h0);
    @(posedge pclk);
    unit_select_line_n <= 1'h0;
    pins(7'h60);
  endtask
  task automatic t_cmd(input int f, input logic rib);
    logic [31:0] x;
    int c;
    x = 32'h0000_1800;
    x[14:13] = 2'(f);
    c = wcnt;
    ctrl.send(4'h1 << f, words[f], rib, 250);
    chk_reg(32'(wcnt - c), 32'h1);
    pins(7'h6F);
    x[f] = 1'h1;
    x[6] = rib && f == 1;
    rdc(ST, x, 1'h0);
    rdc(FH, {28'h0, words[f][11:8]}, 1'h0);
    rdc(FL, {24'h0, words[f][7:0]}, 1'h0);
    wr(CL, 32'h0000_000C);
    x[f] = 1'h0;
    x[6] = 1'h0;
    rdc(ST, x, 1'h0);
    pins(7'h60);
  endtask
  task automatic t_refuse;
    int c;
    c = wcnt;
    @(posedge pclk);
    unit_select_line_n <= 1'h1;
    ctrl.send(4'h1, 12'h123, 1'h0, 250);
    chk_reg(32'(wcnt - c), 32'h0);
    @(posedge pclk);
    unit_select_line_n <= 1'h0;
    rdc(ST, 32'h0000_7800, 1'h0);
    ctrl.send(4'h1, 12'h123, 1'h0, 2);
    pins(7'h60);
    ctrl.send(4'h2, 12'h456, 1'h0, 250);
    c = wcnt;
    ctrl.send(4'h4, 12'h789, 1'h0, 250);
    chk_reg(32'(wcnt - c), 32'h0);
    rdc(ST, 32'h0000_3802, 1'h0);
    rdc(FL, 32'h0000_0056, 1'h0);
    wr(CL, 32'h0000_0004);
  endtask
  task automatic t_restore;
    int c;
    @(posedge pclk);
    restore_n <= 1'h0;
    repeat (2) @(posedge pclk);
    restore_n <= 1'h1;
    pins(7'h2F);
    rdc(ST, 32'h0000_3980, 1'h0);
    c = wcnt;
    ctrl.send(4'h8, 12'hABC, 1'h0, 250);
    chk_reg(32'(wcnt - c), 32'h0);
    wr(CL, 32'h0000_0001);
    pins(7'h60);
    wr(CL, 32'h0000_0002);
    rdc(ST, 32'h0000_3880, 1'h0);
    pins(7'h2F);
    wr(CL, 32'h0000_0001);
    ctrl.send(4'h2, 12'h5A5, 1'h1, 250);
    wr(CL, 32'h0000_0040);
    rdc(ST, 32'h0000_3880, 1'h0);
    wr(CL, 32'h0000_0001);
    pins(7'h60);
  endtask
  task automatic t_check;
    int c;
    wr(CT, 32'h0000_0001);
    pins(7'h2F);
    c = wcnt;
    ctrl.send(4'h1, 12'h321, 1'h0, 250);
    chk_reg(32'(wcnt - c), 32'h0);
    wr(CT, 32'h0);
    pins(7'h2F);
    wr(CL, 32'h0000_0002);
    wr(CT, 32'h0);
    wr(CL, 32'h0000_0001);
    pins(7'h60);
    wr(CT, 32'h0000_0002);
    pins(7'h6F);
    wr(CT, 32'h0);
    @(posedge pclk);
    ribbon_depleted_n <= 1'h0;
    pins(7'h62);
    @(posedge pclk);
    ribbon_depleted_n <= 1'h1;
  endtask
  // Combined strobes: wheel with carriage, then wheel with feed.
  task automatic t_pb;
    ctrl.send(4'h6, 12'h9C3, 1'h0, 250);
    rdc(ST, 32'h0000_3816, 1'h0);
    wr(CL, 32'h0000_0004);
    ctrl.send(4'h3, 12'h9C3, 1'h0, 250);
    rdc(ST, 32'h0000_3833, 1'h0);
    wr(CL, 32'h0000_0004);
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'h0;
    forever #2 pclk = ~pclk;
  end
  initial begin
    repeat (40000) @(posedge pclk);
    err_count++;
    $display("CHECK FAILED %0t: run did not finish", $time);
    tally_and_finish;
  end
  initial begin
    presetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    unit_select_line_n = 1'h1;
    restore_n = 1'h1;
    ribbon_depleted_n = 1'h1;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    t_idle;
    for (int f = 0; f < 4; f++) begin
      t_cmd(f, 1'h1);
    end
    t_refuse;
    t_restore;
    t_check;
    t_pb;
    tally_and_finish;
  end
endmodule
`default_nettype wire
